// *** core/watchdog_pkg.sv ***
// constants for the fixed-interval watchdog
// assumes a single 25 MHz reference clock
`default_nettype none
package watchdog_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // timeout in milliseconds, as printed (0.8 s)
    localparam int unsigned TIMEOUT_MS = 800;
    // longest time rounds down to whole cycles
    localparam longint unsigned TIMEOUT_CYCLES = (longint'(TIMEOUT_MS) * CLK_HZ) / 1000;
    localparam int CNT_W = 25;
    localparam logic ARMED_RESET = 1'b1;
    localparam logic AUTO_SERVICE_RESET = 1'b1;
    localparam logic [7:0] REBOOT_PULSE_CYCLES = 8'h10;
endpackage
`default_nettype wire

// *** core/fixed_timeout_watchdog.sv ***
// fixed-interval watchdog that reboots the module when not kicked in time
// assumes commands are one-cycle pulses synchronous to ref_clk_i,
// and that the package sets the cycle counts for the reference clock
// Functional notes
// RULE_01 - timeout fixed at 0.8 s, not configurable
// RULE_02 - enabled and counting right after power-on
// RULE_03 - missed 0.8 s timeout asserts module reboot
// RULE_04 - arm and disarm commands; disarmed never reboots
// RULE_05 - software kicks before 0.8 s elapses
// RULE_06 - firmware auto-kicks until user takes over
// RULE_07 - every kick restarts count from zero
`default_nettype none
// TIMEOUT counts clock cycles; the default is the fixed interval at
// the reference clock, and only a bench should shrink it
module fixed_timeout_watchdog
    import watchdog_pkg::*;
#(
    parameter logic [CNT_W-1:0] TIMEOUT = CNT_W'(TIMEOUT_CYCLES)
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic watchdog_arm_call_i,
    input wire logic watchdog_disarm_call_i,
    input wire logic watchdog_kick_call_i,
    input wire logic firmware_kick_i,
    input wire logic user_takeover_i,
    output logic armed_o,
    output logic auto_service_o,
    output logic [CNT_W-1:0] elapsed_o,
    output logic reboot_o
);

    // one unkicked interval, edge by edge:
    //   elapsed steps 0 .. TIMEOUT-1, once per clock
    //   the edge that leaves TIMEOUT-1 loads the pulse counter
    //   and raises reboot_o at the same edge
    //   reboot_o then stands for REBOOT_PULSE_CYCLES clocks
    //   counting starts again from zero when the pulse ends
    //   a kick on any cycle sends elapsed back to zero
    //   the enable survives the pulse; rst_i or an arm command re-arms

    // enable state
    logic armed;
    logic next_armed;

    // automatic firmware servicing state
    logic auto_service;
    logic next_auto_service;

    // cycles since the last accepted kick
    logic [CNT_W-1:0] elapsed;
    logic [CNT_W-1:0] next_elapsed;

    // cycles left of the reboot pulse
    // eight bits are enough for the pulse length
    logic [7:0] reboot_cnt;
    logic [7:0] next_reboot_cnt;

    // registered reboot output
    logic reboot;
    logic next_reboot;

    // decoded events of this cycle
    logic kick_now;
    logic pulse_busy;

    // software kicks always count, firmware kicks only while
    // automatic servicing is still on
    function automatic logic kick_accepted(
        input logic user_kick,
        input logic fw_kick,
        input logic servicing
    );
        logic accepted;
        accepted = user_kick;
        if (servicing && fw_kick) begin
            accepted = 1'b1;
        end
        return accepted;
    endfunction

    // true on the last cycle of the interval; >= rather than ==
    // so a count that somehow passed the limit still ends
    function automatic logic interval_spent(
        input logic [CNT_W-1:0] count,
        input logic [CNT_W-1:0] limit
    );
        logic spent;
        spent = 1'b0;
        if (count >= limit - CNT_W'(1)) begin
            spent = 1'b1;
        end
        return spent;
    endfunction

    // true while a reboot pulse is still being driven
    function automatic logic pulse_running(
        input logic [7:0] count
    );
        logic running;
        running = 1'b0;
        if (count != 8'h00) begin
            running = 1'b1;
        end
        return running;
    endfunction

    // kick decode
    always_comb begin
        kick_now = kick_accepted(watchdog_kick_call_i, firmware_kick_i, auto_service); // [RULE_06]
    end

    // pulse decode
    always_comb begin
        pulse_busy = pulse_running(reboot_cnt);
    end

    // enable group: disarm wins when both commands meet;
    // arming never cuts a running pulse short
    always_comb begin
        next_armed = armed;
        if (watchdog_disarm_call_i) begin
            next_armed = 1'b0; // [RULE_04]
        end else if (watchdog_arm_call_i) begin
            next_armed = 1'b1; // [RULE_04]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            armed <= ARMED_RESET; // [RULE_02]
        end else begin
            armed <= next_armed;
        end
    end

    // servicing group: once taken over, only reset gives it back
    always_comb begin
        next_auto_service = auto_service;
        if (user_takeover_i) begin
            next_auto_service = 1'b0; // [RULE_06]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            auto_service <= AUTO_SERVICE_RESET; // [RULE_06]
        end else begin
            auto_service <= next_auto_service;
        end
    end

    // counting group
    // the count is held at zero during the pulse so that a fresh
    // interval starts once the pulse ends; kicks in that time are lost
    // priority: pulse, disarm, kick, expiry, count
    always_comb begin
        next_elapsed = elapsed;
        if (pulse_busy) begin
            next_elapsed = '0;
        end else if (!next_armed) begin
            next_elapsed = '0; // [RULE_04]
        end else if (kick_now) begin
            next_elapsed = '0; // [RULE_07]
        end else if (interval_spent(elapsed, TIMEOUT)) begin
            next_elapsed = '0; // [RULE_01]
        end else begin
            next_elapsed = elapsed + CNT_W'(1); // [RULE_02]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            elapsed <= '0;
        end else begin
            elapsed <= next_elapsed;
        end
    end

    // reboot pulse group: a fixed-length pulse starts when the
    // interval runs out unkicked; a kick or disarm on that last
    // cycle still saves the module
    always_comb begin
        next_reboot_cnt = reboot_cnt;
        if (pulse_busy) begin
            next_reboot_cnt = reboot_cnt - 8'h01;
        end else if (next_armed && !kick_now && interval_spent(elapsed, TIMEOUT)) begin
            next_reboot_cnt = REBOOT_PULSE_CYCLES; // [RULE_03]
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reboot_cnt <= 8'h00;
        end else begin
            reboot_cnt <= next_reboot_cnt;
        end
    end

    // output flag group: registered so the reboot line never glitches
    // and rises at the same edge that loads the pulse counter
    always_comb begin
        next_reboot = pulse_running(next_reboot_cnt); // [RULE_03]
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            reboot <= 1'b0;
        end else begin
            reboot <= next_reboot;
        end
    end

    // outputs are plain copies of the state flops
    // so none of them is decoded combinationally
    assign armed_o = armed;
    assign auto_service_o = auto_service;
    assign elapsed_o = elapsed;
    assign reboot_o = reboot;
endmodule
`default_nettype wire

// *** sim/wdt_chk_asserts.sv ***
// watchdog port checker
// bound by the bench, TIMEOUT handed on
`default_nettype none
module wdt_chk
    import watchdog_pkg::*;
#(
    parameter logic [CNT_W-1:0] TIMEOUT = 25'h0000032
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic watchdog_disarm_call_i,
    input wire logic watchdog_kick_call_i,
    input wire logic firmware_kick_i,
    input wire logic armed_o,
    input wire logic auto_service_o,
    input wire logic reboot_o,
    input wire logic [CNT_W-1:0] elapsed_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    a_reset_armed: assert property ($past(rst_i) |-> armed_o && elapsed_o == 0)
        else $error("reset");
    a_kick_restart: assert property (watchdog_kick_call_i && !reboot_o |=> elapsed_o == 0)
        else $error("kick");
    a_fixed_interval: assert property ($rose(reboot_o) |-> $past(elapsed_o) == TIMEOUT - 1)
        else $error("interval");
    a_timeout_reboot: assert property (armed_o && !reboot_o && elapsed_o == TIMEOUT - 1
        && !watchdog_kick_call_i && !watchdog_disarm_call_i && !(firmware_kick_i && auto_service_o)
        |=> reboot_o) else $error("no reboot");
    a_disarm_quiet: assert property (watchdog_disarm_call_i |=> !armed_o ##1 !$rose(reboot_o))
        else $error("disarm");
    cover property ($rose(reboot_o));
    cover property (watchdog_disarm_call_i);
    cover property ($fell(auto_service_o));
endmodule
`default_nettype wire

// *** sim/fixed_timeout_watchdog_tb_top.sv ***
// bench: watchdog with a 50-cycle timeout
// needs wdt_chk
`default_nettype none
module fixed_timeout_watchdog_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i = 0, rst_i = 1, arm = 0, dis = 0, kick = 0, fw = 0, tk = 0, ar, au, rb;
    logic [watchdog_pkg::CNT_W-1:0] el;
    int miscompares = 0, num_checks = 0;
    int r;
    always #20 ref_clk_i = ~ref_clk_i;
    fixed_timeout_watchdog #(.TIMEOUT(50)) dut_u (.ref_clk_i, .rst_i, .watchdog_arm_call_i(arm),
        .watchdog_disarm_call_i(dis), .watchdog_kick_call_i(kick), .firmware_kick_i(fw),
        .user_takeover_i(tk), .armed_o(ar), .auto_service_o(au), .elapsed_o(el), .reboot_o(rb));
    task automatic chk(input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("ERROR %0t %h %h", $time, s, e);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d bad %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic go(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask
    // idle edges after a kick: the 50th one starts the reboot pulse
    function automatic logic exp_reboot(input int idle);
        return idle >= 50;
    endfunction
    initial begin
        void'($urandom(32'hAE69));
        go(4);
        rst_i = 0;
        chk(ar, 1);
        go(49);
        chk(rb, 0);
        go(1);
        chk(rb, 1);
        $display("timeout done");
        go(17);
        repeat (20) begin
            kick = 1;
            go(1);
            kick = 0;
            r = $urandom_range(48, 1);
            go(r);
            chk(rb, exp_reboot(r));
        end
        $display("kicks done");
        dis = 1;
        go(1);
        dis = 0;
        go(60);
        chk({rb, el}, 0);
        chk(ar, 0);
        $display("disarm done");
        arm = 1;
        go(1);
        arm = 0;
        chk(ar, 1);
        fw = 1;
        go(60);
        chk(rb, 0);
        tk = 1;
        go(1);
        tk = 0;
        chk(au, 0);
        go(50);
        chk(rb, 1);
        $display("takeover done");
        stop_test;
    end
endmodule
bind fixed_timeout_watchdog wdt_chk #(.TIMEOUT(TIMEOUT)) chk_u (.*);
`default_nettype wire
